// File: hw/core_flags_pkg.sv
// Constants shared by the flag and interrupt control block.
// Assumes one 40 MHz clock and a plain register port with byte-wide data.
`default_nettype none
package core_flags_pkg;
    // Register offsets
    localparam logic [7:0] core_condition_flags_addr   = 8'h0a;
    localparam logic [7:0] irq_enable_and_pending_addr = 8'h0b;
    // Status field positions
    localparam int carry_bit      = 0;
    localparam int half_carry_bit = 1;
    localparam int zero_bit       = 2;
    localparam int signed_wrap_bit = 3;
    localparam int powerdown_bit  = 4;
    localparam int timeout_bit    = 5;
    // Interrupt control field positions
    localparam int global_en_bit  = 0;
    localparam int ext_en_bit     = 1;
    localparam int timer_en_bit   = 2;
    localparam int ext_pend_bit   = 4;
    localparam int timer_pend_bit = 5;
    // Readable masks, unused bits read as zero; status_sw_mask sets the software-writable status bits
    localparam logic [7:0] status_read_mask = 8'h3f;
    localparam logic [7:0] irq_control_reg_read_mask   = 8'h37;
    localparam logic [7:0] status_sw_mask   = 8'h0f;
    // Reset values
    localparam logic [7:0] status_reset = 8'h00;
    localparam logic [7:0] irq_control_reg_reset   = 8'h00;
    // Vectors
    localparam logic [9:0] ext_vector   = 10'h004;
    localparam logic [9:0] timer_vector = 10'h008;
    // Stack geometry
    localparam int stack_depth_default = 4;
    localparam int pc_width            = 10;
    // ALU flag update kinds
    typedef enum logic [2:0]
    {
        alu_none  = 3'h0,
        alu_add   = 3'h1,
        alu_sub   = 3'h2,
        alu_logic = 3'h3,
        alu_rot_c = 3'h4
    } alu_kind_t;
    // Acknowledge sequencer states
    typedef enum logic [1:0]
    {
        ack_idle = 2'b01,
        ack_push = 2'b10
    } ack_state_t;
endpackage : core_flags_pkg
`default_nettype wire

// File: hw/stack_if.sv
// Push/pop carrier between the controller and its return stack.
// Assumes both ends on the same clock.
`default_nettype none
interface stack_if #(parameter int pw = 10);
    logic          push;
    logic          pop;
    logic [pw-1:0] push_data;
    logic [pw-1:0] top_data;
    logic          full;
    logic          empty;
    modport ctrl  (output push, output pop, output push_data, input top_data, input full, input empty);
    modport store (input push, input pop, input push_data, output top_data, output full, output empty);
endinterface : stack_if
`default_nettype wire

// File: hw/return_stack.sv
// Return-address stack of program counter values only.
// Assumes push and pop are never requested in the same cycle.
`default_nettype none
module return_stack
    import core_flags_pkg::*;
#(
    parameter int depth = stack_depth_default
)
(
    input  wire logic clk,
    input  wire logic srst,
    stack_if.store    st
);
    localparam int iw = $clog2(depth);
    logic [pc_width-1:0] slot_reg [depth];
    logic [iw:0]         stack_index_reg;
    logic [iw-1:0]       wr_ptr;
    logic [iw-1:0]       rd_ptr;

    // Circular slots: a push past full overwrites the oldest entry
    assign rd_ptr = wr_ptr - iw'(1);

    // Storage
    always_ff @(posedge clk)
    begin
        if (st.push)
        begin
            slot_reg[wr_ptr] <= st.push_data;
        end
    end

    // Occupancy saturates at depth; pointer wrap needs a power-of-two depth
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            stack_index_reg <= '0;
            wr_ptr          <= '0;
        end
        else if (st.push)
        begin
            wr_ptr          <= wr_ptr + iw'(1);
            stack_index_reg <= stack_index_reg + (iw+1)'(!st.full);
        end
        else if (st.pop && !st.empty)
        begin
            wr_ptr          <= rd_ptr;
            stack_index_reg <= stack_index_reg - 1'b1;
        end
    end

    assign st.full     = (stack_index_reg == (iw+1)'(depth));
    assign st.empty    = (stack_index_reg == '0);
    assign st.top_data = slot_reg[rd_ptr];
endmodule : return_stack
`default_nettype wire

// File: hw/core_flags_irq.sv
// Status flags and two-source interrupt controller of the processor core.
// Assumes the sequencer, timer and watchdog sit on the same clock; the pin is asynchronous.
//
// The plain strobed port is this design's own decision.
`default_nettype none
module core_flags_irq
    import core_flags_pkg::*;
#(
    parameter int stack_depth = stack_depth_default
)
(
    input  wire logic                clk,
    input  wire logic                srst,
    // Register port
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [7:0]          reg_rdata,
    // ALU result and carries
    input  wire logic                alu_valid,
    input  wire alu_kind_t           alu_kind,
    input  wire logic [7:0]          alu_a,
    input  wire logic [7:0]          alu_b,
    input  wire logic                alu_cin,
    input  wire logic [7:0]          alu_result,
    input  wire logic                rot_carry_out,
    // Sequencer events
    input  wire logic                sleep_op,
    input  wire logic                watchdog_clear_op,
    input  wire logic                watchdog_timeout,
    input  wire logic                call_op,
    input  wire logic                subroutine_exit_op,
    input  wire logic                isr_exit_op,
    input  wire logic [pc_width-1:0] pc_current,
    input  wire logic                phase_two_clock,
    input  wire logic                halted,
    // Interrupt sources
    input  wire logic                ext_irq_n,
    input  wire logic                timer_overflow,
    // Sequencer outputs
    output logic                     irq_ack,
    output logic      [pc_width-1:0] irq_vector,
    output logic                     ret_valid,
    output logic      [pc_width-1:0] ret_pc,
    output logic                     wake,
    output logic                     stack_full
);
    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [3:0]       arith_flags_reg;
    logic             powerdown_flag_reg;
    logic             watchdog_timeout_flag_reg;
    logic             global_irq_enable_reg;
    logic             ext_irq_enable_reg;
    logic             timer_irq_enable_reg;
    logic             ext_irq_pending_reg;
    logic             timer_irq_pending_reg;
    logic [2:0]       pin_sync_reg;
    logic             pin_level_reg;
    logic             ext_fall;
    ack_state_t       ack_state_reg;
    logic             ack_ext_reg;
    logic [3:0]       arith_next;
    logic             take_ext;
    logic             take_timer;
    logic             wr_status;
    logic             wr_irq_control_reg;
    logic [7:0]       status_view;
    logic [7:0]       irq_control_reg_view;

    stack_if #(.pw(pc_width)) st ();

    return_stack #(.depth(stack_depth)) u_stack
    (
        .clk  (clk),
        .srst (srst),
        .st   (st)
    );

    // Address decode used by writes
    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction : hit

    assign wr_status = reg_wr && hit(reg_addr, core_condition_flags_addr);
    assign wr_irq_control_reg   = reg_wr && hit(reg_addr, irq_enable_and_pending_addr);

    ////////////////////////////////////////////////////////////////////////
    // ALU flag computation
    always_comb
    begin
        logic [8:0] sum;
        logic [4:0] nib;
        logic [7:0] low7;
        logic       c7;
        sum  = '0;
        nib  = '0;
        low7 = '0;
        c7   = 1'b0;
        arith_next = arith_flags_reg;
        case (alu_kind)
            alu_add:
            begin
                sum  = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, alu_cin};
                nib  = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, alu_cin};
                low7 = {1'b0, alu_a[6:0]} + {1'b0, alu_b[6:0]} + {7'h00, alu_cin};
                c7   = low7[7];
                arith_next[carry_bit]       = sum[8];
                arith_next[half_carry_bit]  = nib[4];
                arith_next[signed_wrap_bit] = c7 ^ sum[8];
                arith_next[zero_bit]        = (alu_result == 8'h00);
            end
            alu_sub:
            begin
                // Subtract as a + ~b + cin; carry out means no borrow
                sum  = {1'b0, alu_a} + {1'b0, ~alu_b} + {8'h00, alu_cin};
                nib  = {1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} + {4'h0, alu_cin};
                low7 = {1'b0, alu_a[6:0]} + {1'b0, ~alu_b[6:0]} + {7'h00, alu_cin};
                c7   = low7[7];
                arith_next[carry_bit]       = sum[8];
                arith_next[half_carry_bit]  = nib[4];
                arith_next[signed_wrap_bit] = c7 ^ sum[8];
                arith_next[zero_bit]        = (alu_result == 8'h00);
            end
            alu_logic:
            begin
                arith_next[zero_bit] = (alu_result == 8'h00);
            end
            alu_rot_c:
            begin
                arith_next[carry_bit] = rot_carry_out;
            end
            default:
            begin
                arith_next = arith_flags_reg;
            end
        endcase
    end

    // Arithmetic flags; ALU update beats a same-cycle software write
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            arith_flags_reg <= status_reset[3:0];
        end
        else if (alu_valid)
        begin
            arith_flags_reg <= arith_next;
        end
        else if (wr_status)
        begin
            arith_flags_reg <= reg_wdata[3:0] & status_sw_mask[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Powerdown and timeout flags, untouched by register writes
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            powerdown_flag_reg <= status_reset[powerdown_bit];
        end
        else if (sleep_op)
        begin
            powerdown_flag_reg <= 1'b1;
        end
        else if (watchdog_clear_op)
        begin
            powerdown_flag_reg <= 1'b0;
        end
    end

    // Timeout set wins over clears so a trip is never lost
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            watchdog_timeout_flag_reg <= status_reset[timeout_bit];
        end
        else if (watchdog_timeout)
        begin
            watchdog_timeout_flag_reg <= 1'b1;
        end
        else if (watchdog_clear_op || sleep_op)
        begin
            watchdog_timeout_flag_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser; edge judged only on the agreeing later stages
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pin_sync_reg  <= 3'h7;
            pin_level_reg <= 1'b1;
        end
        else
        begin
            pin_sync_reg <= {pin_sync_reg[1:0], ext_irq_n};
            if (pin_sync_reg[1] == pin_sync_reg[2])
            begin
                pin_level_reg <= pin_sync_reg[2];
            end
        end
    end

    assign ext_fall = pin_level_reg && (pin_sync_reg[1] == pin_sync_reg[2]) && !pin_sync_reg[2];

    ////////////////////////////////////////////////////////////////////////
    // Acknowledge decision, sampled on the phase-two pulse only
    assign take_ext   = ext_irq_pending_reg && ext_irq_enable_reg;
    assign take_timer = timer_irq_pending_reg && timer_irq_enable_reg && !take_ext;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ack_state_reg <= ack_idle;
            ack_ext_reg   <= 1'b0;
        end
        else
        begin
            case (ack_state_reg)
                ack_idle:
                begin
                    // Full stack holds the request pending; global enable gates all
                    if (phase_two_clock && global_irq_enable_reg && !st.full
                        && (take_ext || take_timer))
                    begin
                        ack_state_reg <= ack_push;
                        ack_ext_reg   <= take_ext;
                    end
                end
                ack_push:
                begin
                    ack_state_reg <= ack_idle;
                end
                default:
                begin
                    ack_state_reg <= ack_idle;
                end
            endcase
        end
    end

    assign irq_ack = (ack_state_reg == ack_push);

    // Vector chosen from the unlatched take_ext on each idle phase-two pulse
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            irq_vector <= '0;
        end
        else if (ack_state_reg == ack_idle && phase_two_clock)
        begin
            irq_vector <= take_ext ? ext_vector : timer_vector;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Enables; acknowledge clears global, interrupt exit sets it
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            global_irq_enable_reg <= irq_control_reg_reset[global_en_bit];
            ext_irq_enable_reg    <= irq_control_reg_reset[ext_en_bit];
            timer_irq_enable_reg  <= irq_control_reg_reset[timer_en_bit];
        end
        else
        begin
            if (irq_ack)
            begin
                global_irq_enable_reg <= 1'b0;
            end
            else if (isr_exit_op)
            begin
                global_irq_enable_reg <= 1'b1;
            end
            else if (wr_irq_control_reg)
            begin
                global_irq_enable_reg <= reg_wdata[global_en_bit];
            end
            if (wr_irq_control_reg)
            begin
                ext_irq_enable_reg   <= reg_wdata[ext_en_bit];
                timer_irq_enable_reg <= reg_wdata[timer_en_bit];
            end
        end
    end

    // Pending flags: a new event beats both acknowledge and software clear
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ext_irq_pending_reg   <= irq_control_reg_reset[ext_pend_bit];
            timer_irq_pending_reg <= irq_control_reg_reset[timer_pend_bit];
        end
        else
        begin
            if (ext_fall)
            begin
                ext_irq_pending_reg <= 1'b1;
            end
            else if (irq_ack && ack_ext_reg)
            begin
                ext_irq_pending_reg <= 1'b0;
            end
            else if (wr_irq_control_reg)
            begin
                ext_irq_pending_reg <= reg_wdata[ext_pend_bit];
            end
            if (timer_overflow)
            begin
                timer_irq_pending_reg <= 1'b1;
            end
            else if (irq_ack && !ack_ext_reg)
            begin
                timer_irq_pending_reg <= 1'b0;
            end
            else if (wr_irq_control_reg)
            begin
                timer_irq_pending_reg <= reg_wdata[timer_pend_bit];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stack traffic: program counter only, never the status
    assign st.push      = irq_ack || call_op;
    assign st.push_data = pc_current;
    assign st.pop       = (subroutine_exit_op || isr_exit_op) && !st.push;
    assign ret_pc       = st.top_data;
    assign ret_valid    = st.pop;
    assign stack_full   = st.full;

    // Wake from halt on any new pending source event
    assign wake = halted && (ext_fall || timer_overflow);

    ////////////////////////////////////////////////////////////////////////
    // Read path, one cycle after the strobe
    assign status_view = {2'b00, watchdog_timeout_flag_reg, powerdown_flag_reg, arith_flags_reg};
    assign irq_control_reg_view   = {2'b00, timer_irq_pending_reg, ext_irq_pending_reg, 1'b0,
                          timer_irq_enable_reg, ext_irq_enable_reg, global_irq_enable_reg};

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            case (reg_addr)
                core_condition_flags_addr:   reg_rdata <= status_view & status_read_mask;
                irq_enable_and_pending_addr: reg_rdata <= irq_control_reg_view & irq_control_reg_read_mask;
                default:                     reg_rdata <= 8'h00;
            endcase
        end
        else
        begin
            reg_rdata <= 8'h00;
        end
    end
endmodule : core_flags_irq
`default_nettype wire

// File: bench/seq_partner.sv
// Partner model: sequencer phase pulses, program counter and timer.
// Assumes the block's clock and its synchronous reset.
`default_nettype none
module seq_partner
    import core_flags_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire logic                tmr_req,
    output logic                     phase_two_clock,
    output logic                     timer_overflow,
    output logic      [pc_width-1:0] pc_current
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph_reg;
    ////////////////////////////////////////////////////////////
    // Four clocks per machine cycle, one phase-two pulse each
    always_ff @(posedge clk)
    begin
        ph_reg          <= srst ? 2'h0 : ph_reg + 2'h1;
        phase_two_clock <= !srst && ph_reg == 2'h1;
        pc_current      <= srst ? 10'h000 : pc_current + {9'h000, phase_two_clock};
    end
    // Overflow follows tmr_req one clock later and lasts as long as tmr_req is held
    always_ff @(posedge clk)
    begin
        timer_overflow <= !srst && tmr_req;
    end
endmodule : seq_partner
`default_nettype wire

// File: bench/core_flags_irq_assertions.sv
// Checker watching the ports of the flag and interrupt block.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none
module core_flags_irq_checker
    import core_flags_pkg::*;
(
    input wire logic                clk,
    input wire logic                srst,
    input wire logic [7:0]          reg_addr,
    input wire logic                reg_rd,
    input wire logic [7:0]          reg_rdata,
    input wire logic                alu_valid,
    input wire alu_kind_t           alu_kind,
    input wire logic [7:0]          alu_result,
    input wire logic                sleep_op,
    input wire logic                watchdog_timeout,
    input wire logic                subroutine_exit_op,
    input wire logic                isr_exit_op,
    input wire logic                phase_two_clock,
    input wire logic                halted,
    input wire logic                irq_ack,
    input wire logic [pc_width-1:0] irq_vector,
    input wire logic                ret_valid,
    input wire logic                wake,
    input wire logic                stack_full
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Status read request, used by several properties
    wire logic st_rd = reg_rd && reg_addr == core_condition_flags_addr;
    ////////////////////////////////////////////////////////////
    property p_stat_spare;
        st_rd |=> reg_rdata[7:6] == 2'h0;
    endproperty
    a_stat_spare: assert property (p_stat_spare) else $error("status spare bits set");
    property p_ctl_spare;
        reg_rd && reg_addr == irq_enable_and_pending_addr |=> reg_rdata[7:6] == 2'h0 && !reg_rdata[3];
    endproperty
    a_ctl_spare: assert property (p_ctl_spare) else $error("control spare bits set");
    property p_ack_t2;
        irq_ack |-> $past(phase_two_clock);
    endproperty
    a_ack_t2: assert property (p_ack_t2) else $error("ack off phase two");
    property p_ack_once;
        irq_ack |=> !irq_ack;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack not single");
    property p_ack_vec;
        irq_ack |-> irq_vector == ext_vector || irq_vector == timer_vector;
    endproperty
    a_ack_vec: assert property (p_ack_vec) else $error("bad vector");
    property p_full_hold;
        stack_full && phase_two_clock |=> !irq_ack;
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("ack while full");
    property p_ret_src;
        ret_valid |-> subroutine_exit_op || isr_exit_op;
    endproperty
    a_ret_src: assert property (p_ret_src) else $error("pop without return");
    property p_wake;
        wake |-> halted;
    endproperty
    a_wake: assert property (p_wake) else $error("wake while running");
    property p_zero;
        alu_valid && alu_kind == alu_logic && alu_result == 8'h00 ##1 !alu_valid ##1 st_rd && !alu_valid
            |=> reg_rdata[zero_bit];
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag missing");
    property p_sleep;
        sleep_op && !watchdog_timeout ##1 !watchdog_timeout ##1 st_rd |=> reg_rdata[5:4] == 2'h1;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
    c_ext: cover property (irq_ack && irq_vector == ext_vector);
    c_tmr: cover property (irq_ack && irq_vector == timer_vector);
    c_full: cover property (stack_full && phase_two_clock);
endmodule : core_flags_irq_checker
bind core_flags_irq core_flags_irq_checker chk (.clk, .srst, .reg_addr, .reg_rd, .reg_rdata, .alu_valid,
    .alu_kind, .alu_result, .sleep_op, .watchdog_timeout, .subroutine_exit_op, .isr_exit_op,
    .phase_two_clock, .halted, .irq_ack, .irq_vector, .ret_valid, .wake, .stack_full);
`default_nettype wire

// File: bench/core_flags_irq_tb.sv
// Self-checking bench for the flag and interrupt block.
// Assumes the partner model supplies phase pulses, PC and timer events.
`default_nettype none
module core_flags_irq_tb
    import core_flags_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                clk, srst, reg_wr, reg_rd, alu_valid, alu_cin, rot_carry_out;
    logic                halted, ext_irq_n, phase_two_clock, timer_overflow;
    logic                irq_ack, ret_valid, wake, stack_full;
    logic [7:0]          reg_addr, reg_wdata, reg_rdata, alu_a, alu_b, alu_result, a, b, st;
    logic [6:0]          ev;
    logic [pc_width-1:0] pc_current, irq_vector, ret_pc, stk[$], acks[$];
    alu_kind_t           alu_kind;
    int                  fails, total_checks, wk;
    core_flags_irq #(.stack_depth(4)) dut (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .alu_valid, .alu_kind, .alu_a, .alu_b, .alu_cin, .alu_result, .rot_carry_out, .sleep_op(ev[0]),
        .watchdog_clear_op(ev[1]), .watchdog_timeout(ev[2]), .call_op(ev[3]), .subroutine_exit_op(ev[4]),
        .isr_exit_op(ev[5]), .pc_current, .phase_two_clock, .halted, .ext_irq_n, .timer_overflow,
        .irq_ack, .irq_vector, .ret_valid, .ret_pc, .wake, .stack_full);
    seq_partner sp (.clk, .srst, .tmr_req(ev[6]), .phase_two_clock, .timer_overflow, .pc_current);
    ////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic report_and_stop;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : check
    // Stack and acknowledge model, sampled on the design's own edge
    always @(posedge clk)
    begin
        if (!srst && (ev[3] || irq_ack))
            stk.push_back(pc_current);
        if (!srst && irq_ack)
            acks.push_back(irq_vector);
        if (!srst && wake)
            wk++;
        if (!srst && ret_valid)
            check(ret_pc === stk.pop_back(), "return pc");
    end
    task automatic wr(input logic [7:0] ad, d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= ad;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] ad, exp, input string m);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= ad;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        check(reg_rdata === exp, m);
    endtask : rd
    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev    <= 7'h00;
        @(negedge clk);
    endtask : pulse
    task automatic ext_fall;
        @(posedge clk);
        ext_irq_n <= 1'b0;
        repeat (6) @(posedge clk);
        ext_irq_n <= 1'b1;
    endtask : ext_fall
    // Fixed window; absence of an ack can only be judged over a span
    task automatic ack_chk(input int want, input logic [pc_width-1:0] v);
        repeat (16) @(negedge clk);
        check(acks.size() == want && (want == 0 || acks[0] === v), "ack");
        acks.delete();
    endtask : ack_chk
    task automatic alu(input alu_kind_t k, input logic [7:0] x, y, input logic c);
        int         s, h, v;
        logic [7:0] yy, r;
        yy = (k == alu_sub) ? ~y : y;
        s  = x + yy + c;
        h  = x[3:0] + yy[3:0] + c;
        v  = x[6:0] + yy[6:0] + c;
        r  = (k == alu_logic) ? x ^ y : ((k == alu_rot_c) ? {x[6:0], c} : s[7:0]);
        @(posedge clk);
        alu_valid     <= 1'b1;
        alu_kind      <= k;
        alu_a         <= x;
        alu_b         <= y;
        alu_cin       <= c;
        alu_result    <= r;
        rot_carry_out <= x[7];
        @(posedge clk);
        alu_valid     <= 1'b0;
        if (k == alu_rot_c)
            st[0] = x[7];
        else if (k == alu_logic)
            st[2] = (r == 8'h00);
        else
            st[3:0] = {v[7] ^ s[8], r == 8'h00, h[4], s[8]};
    endtask : alu
    ////////////////////////////////////////////////////////////
    // Guard against a hang
    initial
    begin
        repeat (5000) @(posedge clk);
        fails++;
        report_and_stop();
    end
    initial
    begin
        {srst, ext_irq_n} = 2'h3;
        {reg_wr, reg_rd, alu_valid, alu_cin, rot_carry_out, halted, ev} = 13'h0000;
        {reg_addr, reg_wdata, alu_a, alu_b, alu_result} = 40'h00_0000_0000;
        alu_kind = alu_none;
        void'($urandom(32'h7ad224e2));
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rd(8'h0a, 8'h00, "status reset");
        rd(8'h0b, 8'h00, "control reset");
        rd(8'h0c, 8'h00, "unmapped");
        wr(8'h0b, 8'hc8);
        rd(8'h0b, 8'h00, "control spare");
        wr(8'h0a, 8'hff);
        st = 8'h0f;
        rd(8'h0a, st, "status write");
        for (int i = 0; i < 40; i++)
        begin
            a = 8'($urandom);
            b = (i % 3 == 0) ? a : 8'($urandom);
            alu(alu_kind_t'(3'(1 + i % 4)), a, b, 1'($urandom));
            rd(8'h0a, st, "alu flags");
        end
        pulse(2);
        st[5] = 1'b1;
        rd(8'h0a, st, "timeout");
        wr(8'h0a, 8'h00);
        st[3:0] = 4'h0;
        rd(8'h0a, st, "write keeps");
        pulse(0);
        st[5:4] = 2'h1;
        rd(8'h0a, st, "sleep");
        pulse(1);
        st[5:4] = 2'h0;
        rd(8'h0a, st, "wdt clear");
        wr(8'h0b, 8'h03);
        ext_fall();
        ack_chk(1, ext_vector);
        rd(8'h0b, 8'h02, "ack clears");
        wr(8'h0b, 8'h06);
        pulse(6);
        ack_chk(0, 10'h000);
        rd(8'h0b, 8'h26, "timer latched");
        pulse(5);
        ack_chk(1, timer_vector);
        pulse(4);
        rd(8'h0b, 8'h06, "plain return");
        ext_fall();
        pulse(6);
        ack_chk(0, 10'h000);
        rd(8'h0b, 8'h36, "both pending");
        wr(8'h0b, 8'h37);
        ack_chk(1, ext_vector);
        rd(8'h0b, 8'h26, "ext served");
        pulse(5);
        ack_chk(1, timer_vector);
        pulse(5);
        rd(8'h0b, 8'h07, "exit enables");
        repeat (4) pulse(3);
        check(stack_full === 1'b1, "full");
        ext_fall();
        ack_chk(0, 10'h000);
        pulse(4);
        ack_chk(1, ext_vector);
        check(stack_full === 1'b1, "full again");
        repeat (4) pulse(4);
        check(stack_full === 1'b0, "drained");
        @(posedge clk);
        halted <= 1'b1;
        ext_fall();
        pulse(6);
        repeat (2) @(negedge clk);
        check(wk === 2, "wake");
        @(posedge clk);
        halted <= 1'b0;
        srst   <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        stk.delete();
        rd(8'h0b, 8'h00, "second reset");
        report_and_stop();
    end
endmodule : core_flags_irq_tb
`default_nettype wire
